// file: logic/tad_pkg.sv
// Constants and register map of the transient acceleration event detector
package tad_pkg;

  // Register offsets
  localparam logic [7:0] TAD_ADDR_CONFIG = 8'h1d;
  localparam logic [7:0] TAD_ADDR_SOURCE = 8'h1e;
  localparam logic [7:0] TAD_ADDR_THRESHOLD = 8'h1f;

  // Reset values
  localparam logic [7:0] TAD_CONFIG_RST = 8'h00;
  localparam logic [7:0] TAD_THRESHOLD_RST = 8'h00;
  localparam logic [7:0] TAD_SOURCE_RST = 8'h00;

  // Configuration fields
  localparam int TAD_CFG_BYPASS_BIT = 0;
  localparam int TAD_CFG_XEN_BIT = 1;
  localparam int TAD_CFG_YEN_BIT = 2;
  localparam int TAD_CFG_ZEN_BIT = 3;
  localparam int TAD_CFG_LATCH_BIT = 4;

  // Source fields: flag and polarity of axis i at 2i+1 and 2i
  localparam int TAD_SRC_ACTIVE_BIT = 6;

  // Threshold fields
  localparam int TAD_THR_MODE_BIT = 7;
  localparam int TAD_THR_CODE_MSB = 6;

  // Per-axis threshold byte fields
  localparam int TAD_PA_HI_BIT = 0;
  localparam int TAD_PA_LO_MSB = 7;
  localparam int TAD_PA_LO_LSB = 2;

  // Full-scale codes
  localparam logic [1:0] TAD_RANGE_2G = 2'h0;
  localparam logic [1:0] TAD_RANGE_4G = 2'h1;

  // Magnitude scaling: mg = counts8g * 125 / 128, code weight 63 mg
  localparam logic [20:0] TAD_MG_NUM = 21'h00007d;
  localparam logic [20:0] TAD_THR_WEIGHT = 21'h001f80;
  localparam logic [13:0] TAD_LN_CLAMP = 14'h1000;

endpackage

// file: logic/tad_axis_cmp.sv
// Per-axis input select, range scaling and threshold compare
`timescale 1ns/1ps
module tad_axis_cmp #(
  parameter int SW = 14
) (
  // Samples
  input wire logic [SW-1:0] raw_sample,
  input wire logic [SW-1:0] filt_sample,
  // Setup
  input wire logic bypass_filter,
  input wire logic axis_enable,
  input wire logic [1:0] full_scale_range,
  input wire logic low_noise,
  input wire logic [6:0] threshold_code,
  // Result
  output logic over_thr,
  output logic below_neg
);

  logic [SW-1:0] sel;
  logic [SW-1:0] mag;
  logic [SW-1:0] mag8;
  logic [SW-1:0] mag_lim;
  logic [20:0] lhs;
  logic [20:0] rhs;

  always_comb begin
    sel = bypass_filter ? raw_sample : filt_sample;
    mag = sel[SW-1] ? (~sel + 1'b1) : sel;
    // Bring every range to 8 g counts so the code weight stays fixed
    case (full_scale_range)
      tad_pkg::TAD_RANGE_2G: mag8 = mag >> 2;
      tad_pkg::TAD_RANGE_4G: mag8 = mag >> 1;
      default: mag8 = mag;
    endcase
    mag_lim = (low_noise && mag8 > tad_pkg::TAD_LN_CLAMP) ?
      tad_pkg::TAD_LN_CLAMP : mag8;
    lhs = 21'(mag_lim) * tad_pkg::TAD_MG_NUM;
    rhs = 21'(threshold_code) * tad_pkg::TAD_THR_WEIGHT;
    over_thr = axis_enable && (lhs > rhs);
    below_neg = sel[SW-1];
  end

endmodule // tad_axis_cmp

// file: logic/tad_debounce.sv
// Debounce counter of the transient function
`timescale 1ns/1ps
module tad_debounce #(
  parameter int CW = 8
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // Step and condition
  input wire logic step,
  input wire logic cond,
  input wire logic clear_mode,
  input wire logic [CW-1:0] limit,
  // Result
  output logic qualified,
  output logic [CW-1:0] level
);

  logic [CW-1:0] cnt_ff;
  logic [CW:0] cnt_inc;

  assign cnt_inc = {1'b0, cnt_ff} + 1'b1;
  assign qualified = step && cond && (cnt_inc >= {1'b0, limit});
  assign level = cnt_ff;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_ff <= '0;
    end else if (clk_en && step) begin
      if (cond) begin
        // Saturate rather than wrap so a long event stays qualified
        if (!cnt_inc[CW]) begin
          cnt_ff <= cnt_inc[CW-1:0];
        end
      end else if (clear_mode) begin
        cnt_ff <= '0;
      end else if (cnt_ff != '0) begin
        cnt_ff <= cnt_ff - 1'b1;
      end
    end
  end

endmodule // tad_debounce

// file: logic/tad_detector.sv
// Transient acceleration event detector with its three registers
`timescale 1ns/1ps
module tad_detector #(
  parameter int SW = 14
) (
  // Clock, reset, enable
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd_en,
  output logic [7:0] reg_rdata,
  // Samples, one set per output_sample_rate period
  input wire logic sample_valid,
  input wire logic [SW-1:0] raw_x,
  input wire logic [SW-1:0] raw_y,
  input wire logic [SW-1:0] raw_z,
  input wire logic [SW-1:0] filt_x,
  input wire logic [SW-1:0] filt_y,
  input wire logic [SW-1:0] filt_z,
  // Settings held in other registers of the sensor
  input wire logic [1:0] full_scale_range,
  input wire logic low_noise,
  input wire logic hybrid_mode,
  input wire logic [7:0] debounce_count_value,
  input wire logic per_axis_thr_en,
  input wire logic [7:0] y_thr_hi_byte,
  input wire logic [7:0] y_thr_lo_byte,
  input wire logic [7:0] z_thr_hi_byte,
  input wire logic [7:0] z_thr_lo_byte,
  // Event outputs
  output logic event_flag,
  output logic any_axis_active,
  output logic [7:0] debounce_level
);

  // Register state
  logic [7:0] config_ff;
  logic [7:0] threshold_ff;
  logic [2:0] flag_ff;
  logic [2:0] pol_ff;
  logic active_ff;
  logic [7:0] rdata_ff;
  logic event_ff;
  logic phase_ff;
  logic [7:0] level_ff;

  // Next values
  logic [2:0] nxt_flag;
  logic [2:0] nxt_pol;
  logic nxt_active;

  // Decoded controls
  logic latch_en;
  logic bypass;
  logic [2:0] axis_en;
  logic clear_mode;
  logic [6:0] threshold_code;
  logic [6:0] thr_code [3];
  logic src_read;
  logic step;

  // Per-axis compare results, debounce outputs and source update terms
  logic [2:0] over;
  logic [2:0] neg;
  logic [2:0] hit;
  logic cond;
  logic qualified;
  logic [7:0] dbc_level;
  logic [2:0] base_flag;
  logic [2:0] base_pol;
  logic hold;
  logic [7:0] source_val;

  assign latch_en = config_ff[tad_pkg::TAD_CFG_LATCH_BIT];
  assign bypass = config_ff[tad_pkg::TAD_CFG_BYPASS_BIT];
  assign axis_en = {config_ff[tad_pkg::TAD_CFG_ZEN_BIT],
                    config_ff[tad_pkg::TAD_CFG_YEN_BIT],
                    config_ff[tad_pkg::TAD_CFG_XEN_BIT]};
  assign clear_mode = threshold_ff[tad_pkg::TAD_THR_MODE_BIT];
  assign threshold_code = threshold_ff[tad_pkg::TAD_THR_CODE_MSB:0];
  assign src_read = reg_rd_en && (reg_addr == tad_pkg::TAD_ADDR_SOURCE);

  // Threshold per axis: shared code, or for Y and Z split fields from other registers
  always_comb begin
    thr_code[0] = threshold_code;
    if (per_axis_thr_en) begin
      thr_code[1] = {y_thr_hi_byte[tad_pkg::TAD_PA_HI_BIT],
        y_thr_lo_byte[tad_pkg::TAD_PA_LO_MSB:tad_pkg::TAD_PA_LO_LSB]};
      thr_code[2] = {z_thr_hi_byte[tad_pkg::TAD_PA_HI_BIT],
        z_thr_lo_byte[tad_pkg::TAD_PA_LO_MSB:tad_pkg::TAD_PA_LO_LSB]};
    end else begin
      thr_code[1] = threshold_code;
      thr_code[2] = threshold_code;
    end
  end
  // fields joined above when per-axis select is set

  // Hybrid mode takes every second sample so each step lasts twice as long
  assign step = sample_valid && (!hybrid_mode || phase_ff);

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      phase_ff <= 1'b0;
    end else if (clk_en) begin
      if (!hybrid_mode) begin
        phase_ff <= 1'b0;
      end else if (sample_valid) begin
        phase_ff <= ~phase_ff;
      end
    end
  end

  tad_axis_cmp #(
    .SW(SW)
  ) u_cmp_x (
    .raw_sample(raw_x),
    .filt_sample(filt_x),
    .bypass_filter(bypass),
    .axis_enable(axis_en[0]),
    .full_scale_range(full_scale_range),
    .low_noise(low_noise),
    .threshold_code(thr_code[0]),
    .over_thr(over[0]),
    .below_neg(neg[0])
  );

  tad_axis_cmp #(
    .SW(SW)
  ) u_cmp_y (
    .raw_sample(raw_y),
    .filt_sample(filt_y),
    .bypass_filter(bypass),
    .axis_enable(axis_en[1]),
    .full_scale_range(full_scale_range),
    .low_noise(low_noise),
    .threshold_code(thr_code[1]),
    .over_thr(over[1]),
    .below_neg(neg[1])
  );

  tad_axis_cmp #(
    .SW(SW)
  ) u_cmp_z (
    .raw_sample(raw_z),
    .filt_sample(filt_z),
    .bypass_filter(bypass),
    .axis_enable(axis_en[2]),
    .full_scale_range(full_scale_range),
    .low_noise(low_noise),
    .threshold_code(thr_code[2]),
    .over_thr(over[2]),
    .below_neg(neg[2])
  );

  assign hit = over & axis_en;
  assign cond = |hit;

  tad_debounce #(
    .CW(8)
  ) u_debounce (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .step(step),
    .cond(cond),
    .clear_mode(clear_mode),
    .limit(debounce_count_value),
    .qualified(qualified),
    .level(dbc_level)
  );

  // Flag and polarity update; a new event wins over a same-cycle read
  always_comb begin
    base_flag = src_read ? 3'h0 : flag_ff;
    base_pol = src_read ? 3'h0 : pol_ff;
    hold = latch_en && active_ff && !src_read;
    nxt_flag = base_flag;
    nxt_pol = base_pol;
    if (clk_en && qualified && !hold) begin
      nxt_flag = base_flag | hit;
      for (int i = 0; i < 3; i++) begin
        if (hit[i]) begin
          nxt_pol[i] = neg[i];
        end
      end
    end
    nxt_active = |nxt_flag;
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      flag_ff <= 3'h0;
      pol_ff <= 3'h0;
      active_ff <= 1'b0;
    end else if (clk_en) begin
      flag_ff <= nxt_flag;
      pol_ff <= nxt_pol;
      active_ff <= nxt_active;
    end
  end

  // Event output: latched copy, or the live result of the last step
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      event_ff <= 1'b0;
    end else if (clk_en) begin
      if (latch_en) begin
        event_ff <= nxt_active;
      end else if (step) begin
        event_ff <= qualified;
      end
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      level_ff <= 8'h00;
    end else if (clk_en) begin
      level_ff <= dbc_level;
    end
  end

  // Configuration and threshold writes
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      config_ff <= tad_pkg::TAD_CONFIG_RST;
      threshold_ff <= tad_pkg::TAD_THRESHOLD_RST;
    end else if (clk_en && reg_wr_en) begin
      if (reg_addr == tad_pkg::TAD_ADDR_CONFIG) begin
        config_ff <= reg_wdata;
      end
      if (reg_addr == tad_pkg::TAD_ADDR_THRESHOLD) begin
        threshold_ff <= reg_wdata;
      end
    end
  end

  assign source_val = {1'b0, active_ff, flag_ff[2], pol_ff[2],
                       flag_ff[1], pol_ff[1], flag_ff[0], pol_ff[0]};

  // Read data captured on the read strobe; unmapped offsets read zero
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_ff <= 8'h00;
    end else if (clk_en && reg_rd_en) begin
      case (reg_addr)
        tad_pkg::TAD_ADDR_CONFIG: rdata_ff <= config_ff;
        tad_pkg::TAD_ADDR_SOURCE: rdata_ff <= source_val;
        tad_pkg::TAD_ADDR_THRESHOLD: rdata_ff <= threshold_ff;
        default: rdata_ff <= 8'h00;
      endcase
    end
  end

  assign reg_rdata = rdata_ff;
  assign event_flag = event_ff;
  assign any_axis_active = active_ff;
  assign debounce_level = level_ff;

endmodule // tad_detector

// file: dv/tad_detector_assertions.sv
// Port checker of the transient detector
`timescale 1ns/1ps
module tad_chk (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_rdata,
  // Samples and events
  input wire logic sample_valid,
  input wire logic event_flag,
  input wire logic any_axis_active,
  input wire logic [7:0] debounce_level
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  wire rd_ok = reg_rd_en && clk_en;
  wire src_rd = rd_ok && reg_addr == tad_pkg::TAD_ADDR_SOURCE;
  chk_idle_after_rst: assert property ($fell(sys_rst) |->
    !event_flag && !any_axis_active) else $error("busy after reset");
  chk_rdata_holds: assert property (!rd_ok |=> $stable(reg_rdata))
    else $error("read data moved");
  chk_src_ea_bit: assert property (src_rd |=>
    reg_rdata[6] == $past(any_axis_active) && !reg_rdata[7])
    else $error("active bit wrong");
  chk_read_clears: assert property (src_rd && !sample_valid |=>
    !any_axis_active) else $error("read did not clear");
  chk_unmapped_zero: assert property (
    rd_ok && (reg_addr < tad_pkg::TAD_ADDR_CONFIG ||
    reg_addr > tad_pkg::TAD_ADDR_THRESHOLD) |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_active_cause: assert property ($rose(any_axis_active) |->
    $past(sample_valid && clk_en)) else $error("active without sample");
  chk_event_cause: assert property ($rose(event_flag) |->
    // Turning latching on with flags set raises it two edges after the write
    $past(sample_valid && clk_en) || $past(reg_wr_en, 2))
    else $error("event without sample");
  chk_active_stays: assert property (
    !clk_en || !(sample_valid || reg_rd_en) |=> $stable(any_axis_active))
    else $error("active moved");
  chk_level_lag: assert property ($changed(debounce_level) |->
    $past(sample_valid, 2)) else $error("level moved without step");
endmodule // tad_chk
bind tad_detector tad_chk u_chk (.mclk(mclk), .sys_rst(sys_rst),
  .clk_en(clk_en), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
  .reg_rd_en(reg_rd_en), .reg_rdata(reg_rdata), .sample_valid(sample_valid),
  .event_flag(event_flag), .any_axis_active(any_axis_active),
  .debounce_level(debounce_level));

// file: dv/tad_host_model.sv
// Host model driving the register port
`timescale 1ns/1ps
module tad_host_model (
  // Clock
  input wire logic mclk,
  // Register port
  output logic [7:0] reg_addr,
  output logic reg_wr_en,
  output logic [7:0] reg_wdata,
  output logic reg_rd_en,
  input wire logic [7:0] reg_rdata
);
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr_en <= 1'b1;
    @(posedge mclk);
    reg_wr_en <= 1'b0;
    // Idle bus shows inverse so stale values never look valid
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd_en <= 1'b1;
    @(posedge mclk);
    reg_rd_en <= 1'b0;
    reg_addr <= ~a;
    @(posedge mclk);
    d = reg_rdata;
  endtask
endmodule // tad_host_model

// file: dv/transient_accel_event_detector_tb.sv
// Self-checking bench of the transient detector
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_total++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, (a), (b)); end end
module transient_accel_event_detector_tb;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic clk_en = 1'b1;
  logic sv = 1'b0;
  logic ln = 1'b0;
  logic pa = 1'b0;
  logic hm = 1'b0;
  logic [1:0] fsr = 2'h2;
  logic [7:0] dcv = 8'h00;
  logic [41:0] rv = '0, fv = '0;
  logic [31:0] thb = '0;
  wire logic [7:0] addr, wd, rdat, lvl;
  wire logic wen, ren, ev, act;
  logic [7:0] d;
  logic [15:0] rnd = 16'h003e;
  int err_total = 0;
  int checked = 0;
  int cyc = 0;
  always #50 mclk = ~mclk;
  tad_host_model host (.mclk(mclk), .reg_addr(addr), .reg_wr_en(wen),
    .reg_wdata(wd), .reg_rd_en(ren), .reg_rdata(rdat));
  tad_detector uut (.mclk(mclk), .sys_rst(sys_rst), .clk_en(clk_en),
    .reg_addr(addr), .reg_wr_en(wen), .reg_wdata(wd), .reg_rd_en(ren),
    .reg_rdata(rdat), .sample_valid(sv), .raw_x(rv[13:0]),
    .raw_y(rv[27:14]), .raw_z(rv[41:28]), .filt_x(fv[13:0]),
    .filt_y(fv[27:14]), .filt_z(fv[41:28]), .full_scale_range(fsr),
    .low_noise(ln), .hybrid_mode(hm), .debounce_count_value(dcv),
    .per_axis_thr_en(pa), .y_thr_hi_byte(thb[31:24]),
    .y_thr_lo_byte(thb[23:16]), .z_thr_hi_byte(thb[15:8]),
    .z_thr_lo_byte(thb[7:0]), .event_flag(ev), .any_axis_active(act),
    .debounce_level(lvl));
  function automatic logic [15:0] rand16();
    rnd = {rnd[14:0], rnd[15] ^ rnd[13] ^ rnd[12] ^ rnd[10]};
    return rnd;
  endfunction
  // Expected source byte, magnitudes worked in 8 g counts
  function automatic logic [7:0] exp_src(input logic [41:0] s,
    input logic [2:0] en, input logic [6:0] cx, cy, cz);
    logic [7:0] r;
    logic [13:0] v;
    int m;
    r = 8'h00;
    for (int i = 0; i < 3; i++) begin
      v = s[14*i +: 14];
      m = v[13] ? 16384 - int'(v) : int'(v);
      m = m >> (fsr == 2'h0 ? 2 : fsr == 2'h1 ? 1 : 0);
      if (ln && m > 4096) m = 4096;
      if (en[i] && m * 125 > int'(i == 0 ? cx : i == 1 ? cy : cz) * 8064) begin
        r[2*i+1] = 1'b1;
        r[2*i] = v[13];
        r[6] = 1'b1;
      end
    end
    return r;
  endfunction
  task automatic step(input logic [41:0] r, input logic [41:0] f);
    @(posedge mclk);
    sv <= 1'b1;
    rv <= r;
    fv <= f;
    @(posedge mclk);
    sv <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      finish_test();
    end
  end
  initial begin
    logic [47:0] q;
    logic [41:0] s, o;
    logic [7:0] cfg, e;
    repeat (16) @(posedge mclk);
    sys_rst <= 1'b0;
    for (int a = 8'h1d; a < 8'h20; a++) begin
      host.rd(8'(a), d);
      `CHK(d, 8'h00)
    end
    // Latch kept on so each draw is judged alone after a read-clear
    for (int n = 0; n < 40; n++) begin
      q = {rand16(), rand16(), rand16()};
      cfg = q[7:0] | 8'h10;
      host.wr(8'h1d, cfg);
      host.rd(8'h1d, d);
      `CHK(d, cfg)
      host.wr(8'h1f, q[15:8]);
      fsr <= q[17:16];
      ln <= q[18];
      pa <= q[19];
      thb <= {q[47:20], q[3:0]};
      s = 42'({rand16(), rand16(), rand16()});
      o = 42'({rand16(), rand16(), rand16()});
      if (cfg[0]) step(s, o);
      else step(o, s);
      e = exp_src(s, cfg[3:1], q[14:8], pa ? {thb[24], thb[23:18]} : q[14:8],
        pa ? {thb[8], thb[7:2]} : q[14:8]);
      `CHK(ev, e[6])
      host.rd(8'h1e, d);
      `CHK(d, e)
      host.rd(8'h1e, d);
      `CHK(d, 8'h00)
    end
    fsr <= 2'h2;
    ln <= 1'b0;
    pa <= 1'b0;
    host.wr(8'h1f, 8'h01);
    host.wr(8'h1d, 8'h13);
    step(42'h3e8, '0);
    step(42'h3c18, '0);
    host.rd(8'h1e, d);
    `CHK(d, 8'h42)
    host.wr(8'h1d, 8'h03);
    step(42'h3e8, '0);
    step(42'h3c18, '0);
    `CHK(ev, 1'b1)
    step('0, '0);
    `CHK(ev, 1'b0)
    host.rd(8'h1e, d);
    `CHK(d, 8'h43)
    dcv <= 8'h03;
    host.wr(8'h1d, 8'h13);
    for (int k = 0; k < 2; k++) begin
      host.wr(8'h1f, 8'h81);
      step('0, '0);
      host.wr(8'h1f, {k[0], 7'h01});
      step(42'h3e8, '0);
      step(42'h3e8, '0);
      step('0, '0);
      step(42'h3e8, '0);
      @(posedge mclk);
      `CHK(act, 1'b0)
      `CHK(lvl, 8'(2 - k))
      step(42'h3e8, '0);
      `CHK(act, k == 0)
      if (k == 0) begin
        clk_en <= 1'b0;
        host.rd(8'h1e, d);
        clk_en <= 1'b1;
        `CHK(act, 1'b1)
      end
      host.rd(8'h1e, d);
    end
    host.wr(8'h1e, 8'hff);
    host.rd(8'h1e, d);
    `CHK(d, 8'h00)
    host.rd(8'h40, d);
    `CHK(d, 8'h00)
    // Hybrid: only the 2nd, 4th and 6th samples step the counter
    host.wr(8'h1f, 8'h81);
    step('0, '0);
    hm <= 1'b1;
    repeat (4) step(42'h3e8, '0);
    @(posedge mclk);
    `CHK(act, 1'b0)
    `CHK(lvl, 8'h02)
    repeat (2) step(42'h3e8, '0);
    `CHK(act, 1'b1)
    host.rd(8'h1e, d);
    `CHK(d, 8'h42)
    hm <= 1'b0;
    finish_test();
  end
endmodule // transient_accel_event_detector_tb
